/* hdl/csoc_pkg.sv */
// ----------------------------------------------------------------------
// shared constants for the output channel control
// ----------------------------------------------------------------------
package csoc_pkg;

    // output and channel counts
    localparam int CSOC_NUM_CLK  = 10;
    localparam int CSOC_NUM_REF  = 8;
    localparam int CSOC_NUM_CHAN = 5;

    // field positions inside the synchronised configuration word
    localparam int CSOC_OFS_CLK_PD   = 0;
    localparam int CSOC_OFS_CLK_EN   = 10;
    localparam int CSOC_OFS_CLK_STY  = 20;
    localparam int CSOC_OFS_CLK_AMP  = 30;
    localparam int CSOC_OFS_REF_MODE = 50;
    localparam int CSOC_OFS_REF_PD   = 58;
    localparam int CSOC_OFS_REF_EN   = 66;
    localparam int CSOC_OFS_REF_STY  = 74;
    localparam int CSOC_OFS_REF_AMP  = 82;
    localparam int CSOC_OFS_REF_BIAS = 98;
    localparam int CSOC_OFS_CHAN_PD  = 106;
    localparam int CSOC_OFS_BIAS_TYP = 111;
    localparam int CSOC_CFG_W        = 112;

    // values after reset
    localparam logic [CSOC_CFG_W-1:0] CSOC_CFG_RST = 112'h0;
    localparam logic [1:0]            CSOC_AMP_RST = 2'h0;
    localparam logic [9:0]            CSOC_SWING_RST = 10'h0FA;

    // output swing per amplitude code, in mV
    localparam logic [9:0] CSOC_SWING_00 = 10'h0FA;
    localparam logic [9:0] CSOC_SWING_01 = 10'h1F4;
    localparam logic [9:0] CSOC_SWING_10 = 10'h2EE;
    localparam logic [9:0] CSOC_SWING_11 = 10'h3E8;

    // output state, gray coded along off, low, run
    typedef enum logic [1:0]
    {
        CSOC_ST_OFF  = 2'h0,
        CSOC_ST_LOW  = 2'h1,
        CSOC_ST_RUN  = 2'h3,
        CSOC_ST_BIAS = 2'h2
    } csoc_state_t;

    function automatic logic [9:0] csoc_swing_mv(input logic [1:0] amp);
        case (amp)
            2'h0:    csoc_swing_mv = CSOC_SWING_00;
            2'h1:    csoc_swing_mv = CSOC_SWING_01;
            2'h2:    csoc_swing_mv = CSOC_SWING_10;
            default: csoc_swing_mv = CSOC_SWING_11;
        endcase
    endfunction

    // channel that owns output index idx (A=0 .. E=4)
    function automatic logic [2:0] csoc_chan_of(input int idx);
        if (idx < 3)
            csoc_chan_of = 3'h0;
        else if (idx < 5)
            csoc_chan_of = 3'h1;
        else if (idx < 7)
            csoc_chan_of = 3'h2;
        else if (idx < 8)
            csoc_chan_of = 3'h3;
        else
            csoc_chan_of = 3'h4;
    endfunction

endpackage

/* hdl/csoc_out_slot.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// one differential output: state decode and glitch-free gating
// ----------------------------------------------------------------------
module csoc_out_slot (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 sysref_mode,
    input  wire logic                 pd,
    input  wire logic                 en,
    input  wire logic                 style,
    input  wire logic [1:0]           amp,
    input  wire logic                 bias_en,
    input  wire logic                 src,
    input  wire logic                 event_act,
    output var  csoc_pkg::csoc_state_t state,
    output logic                      data,
    output logic                      style_out,
    output logic [1:0]                amp_out,
    output logic [9:0]                swing_mv
);

    csoc_pkg::csoc_state_t next_state;

    // decode power-down, enable, mode, event and bias into a state
    always_comb
    begin
        if (pd)
            next_state = csoc_pkg::CSOC_ST_OFF;
        else if (!sysref_mode)
            next_state = en ? csoc_pkg::CSOC_ST_RUN : csoc_pkg::CSOC_ST_LOW;
        else if (event_act)
            next_state = en ? csoc_pkg::CSOC_ST_RUN : csoc_pkg::CSOC_ST_LOW;
        else if (bias_en)
            next_state = csoc_pkg::CSOC_ST_BIAS;
        else
            next_state = csoc_pkg::CSOC_ST_OFF;
    end

    // state only moves while the source is low, so no pulse is cut short
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            state <= csoc_pkg::CSOC_ST_OFF;
        else if (!src)
            state <= next_state;
    end

    // style and swing follow the same safe point as the state
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            style_out <= 1'b0;
            amp_out   <= csoc_pkg::CSOC_AMP_RST;
            swing_mv  <= csoc_pkg::CSOC_SWING_RST;
        end
        else if (!src)
        begin
            style_out <= style;
            amp_out   <= amp;
            swing_mv  <= csoc_pkg::csoc_swing_mv(amp);
        end
    end

    // output level: copy of the source while running, low otherwise
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            data <= 1'b0;
        else
            data <= (state == csoc_pkg::CSOC_ST_RUN) && src;
    end

endmodule

`default_nettype wire

/* hdl/csoc_chan_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module csoc_chan_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // configuration pins, asynchronous to core_clk
    input  wire logic [9:0]  clock_output_powerdown,
    input  wire logic [9:0]  clock_output_en,
    input  wire logic [9:0]  clock_output_style_sel,
    input  wire logic [19:0] clock_output_amp,
    input  wire logic [7:0]  ref_output_mode_sel,
    input  wire logic [7:0]  ref_output_powerdown,
    input  wire logic [7:0]  ref_output_en,
    input  wire logic [7:0]  ref_output_style_sel,
    input  wire logic [15:0] ref_output_amp,
    input  wire logic [7:0]  line_bias_ctrl,
    input  wire logic [4:0]  chan_output_powerdown,
    input  wire logic        bias_type,
    // divider outputs and SYSREF sequencer, same clock domain
    input  wire logic [4:0]  chan_div,
    input  wire logic        sysref_div,
    input  wire logic        sysref_event,
    // outputs
    output logic [9:0]       clock_output,
    output logic [19:0]      clock_output_state,
    output logic [9:0]       clock_output_style,
    output logic [99:0]      clock_output_swing_mv,
    output logic [7:0]       reference_output,
    output logic [15:0]      reference_output_state,
    output logic [7:0]       reference_output_style,
    output logic [79:0]      reference_output_swing_mv,
    output logic [7:0]       ref_div_sel,
    output logic [7:0]       ref_delay_sel
);

    // ------------------------------------------------------------------
    // configuration synchroniser
    // ------------------------------------------------------------------

    logic [csoc_pkg::CSOC_CFG_W-1:0] cfg_raw;
    logic [csoc_pkg::CSOC_CFG_W-1:0] cfg_meta;
    logic [csoc_pkg::CSOC_CFG_W-1:0] cfg_sync;

    // pack pins in the order of the field offsets
    assign cfg_raw = {bias_type, chan_output_powerdown, line_bias_ctrl,
                      ref_output_amp, ref_output_style_sel, ref_output_en,
                      ref_output_powerdown, ref_output_mode_sel,
                      clock_output_amp, clock_output_style_sel,
                      clock_output_en, clock_output_powerdown};

    // two-stage sync
    // cfg_meta feeds cfg_sync only; each bit is synchronised alone, so a multi-bit pin change can reach logic split over cycles
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cfg_meta <= csoc_pkg::CSOC_CFG_RST;
            cfg_sync <= csoc_pkg::CSOC_CFG_RST;
        end
        else
        begin
            cfg_meta <= cfg_raw;
            cfg_sync <= cfg_meta;
        end
    end

    // ------------------------------------------------------------------
    // field views of the synchronised word
    // ------------------------------------------------------------------

    logic [7:0] mode_s;
    logic [4:0] chan_pd_s;
    logic       bias_type_s;

    assign mode_s      = cfg_sync[csoc_pkg::CSOC_OFS_REF_MODE +: 8];
    assign chan_pd_s   = cfg_sync[csoc_pkg::CSOC_OFS_CHAN_PD +: 5];
    assign bias_type_s = cfg_sync[csoc_pkg::CSOC_OFS_BIAS_TYP];

    csoc_pkg::csoc_state_t clk_st [csoc_pkg::CSOC_NUM_CLK];
    csoc_pkg::csoc_state_t ref_st [csoc_pkg::CSOC_NUM_REF];
    logic [9:0]            clk_pd;
    logic [9:0]            clk_src;
    logic [7:0]            ref_pd;
    logic [7:0]            ref_src;
    logic [7:0]            ref_bias;

    // ------------------------------------------------------------------
    // clock outputs A0 A1 A2 B0 B1 C0 C1 D E0 E1
    // ------------------------------------------------------------------

    // indices 0..7 in channels A-D, 8..9 in channel E
    // E0 and E1 are built here only; no reference slot owns channel E
    for (genvar i = 0; i < csoc_pkg::CSOC_NUM_CLK; i++)
    begin : g_clk
        localparam logic [2:0] CH = csoc_pkg::csoc_chan_of(i);

        // output power-down, with the channel power-down on top
        assign clk_pd[i]  = cfg_sync[csoc_pkg::CSOC_OFS_CLK_PD + i] | chan_pd_s[CH];
        // clock outputs always run from their channel divider
        assign clk_src[i] = chan_div[CH];

        csoc_out_slot u_slot (
            .core_clk    (core_clk),
            .rst_b       (rst_b),
            .sysref_mode (1'b0),
            .pd          (clk_pd[i]),
            .en          (cfg_sync[csoc_pkg::CSOC_OFS_CLK_EN + i]),
            .style       (cfg_sync[csoc_pkg::CSOC_OFS_CLK_STY + i]),
            .amp         (cfg_sync[csoc_pkg::CSOC_OFS_CLK_AMP + 2*i +: 2]),
            .bias_en     (1'b0),
            .src         (clk_src[i]),
            .event_act   (1'b0),
            .state       (clk_st[i]),
            .data        (clock_output[i]),
            .style_out   (clock_output_style[i]),
            .amp_out     (),
            .swing_mv    (clock_output_swing_mv[10*i +: 10])
        );

        assign clock_output_state[2*i +: 2] = clk_st[i];
    end

    // ------------------------------------------------------------------
    // reference outputs A0 A1 A2 B0 B1 C0 C1 D
    // ------------------------------------------------------------------

    for (genvar r = 0; r < csoc_pkg::CSOC_NUM_REF; r++)
    begin : g_ref
        localparam logic [2:0] CH = csoc_pkg::csoc_chan_of(r);

        // per output in clock mode, per channel in SYSREF mode
        assign ref_pd[r] = mode_s[r] ? chan_pd_s[CH]
                         : (cfg_sync[csoc_pkg::CSOC_OFS_REF_PD + r] | chan_pd_s[CH]);

        // global SYSREF divider in SYSREF mode, channel divider otherwise
        assign ref_src[r] = mode_s[r] ? sysref_div : chan_div[CH];

        // bias only with bias type 1 and LVDS style selected
        assign ref_bias[r] = cfg_sync[csoc_pkg::CSOC_OFS_REF_BIAS + r] & bias_type_s
                           & ~cfg_sync[csoc_pkg::CSOC_OFS_REF_STY + r];

        // mode, event and bias drive the state
        csoc_out_slot u_slot (
            .core_clk    (core_clk),
            .rst_b       (rst_b),
            .sysref_mode (mode_s[r]),
            .pd          (ref_pd[r]),
            .en          (cfg_sync[csoc_pkg::CSOC_OFS_REF_EN + r]),
            .style       (cfg_sync[csoc_pkg::CSOC_OFS_REF_STY + r]),
            .amp         (cfg_sync[csoc_pkg::CSOC_OFS_REF_AMP + 2*r +: 2]),
            .bias_en     (ref_bias[r]),
            .src         (ref_src[r]),
            .event_act   (sysref_event),
            .state       (ref_st[r]),
            .data        (reference_output[r]),
            .style_out   (reference_output_style[r]),
            .amp_out     (),
            .swing_mv    (reference_output_swing_mv[10*r +: 10])
        );

        assign reference_output_state[2*r +: 2] = ref_st[r];
    end

    // ------------------------------------------------------------------
    // divider and delay source selects for the analog path
    // ------------------------------------------------------------------

    // one cycle after the synchronised mode bit
    // in clock mode the per-reference delay is ignored (select low)
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ref_div_sel   <= 8'h00;
            ref_delay_sel <= 8'h00;
        end
        else
        begin
            ref_div_sel   <= mode_s;
            ref_delay_sel <= mode_s;
        end
    end

    // ------------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rst_b);

    a_div_sel_mode: assert property (##1 ref_div_sel == $past(mode_s))
        else $error("reference divider select does not follow mode");

    a_delay_sel_mode: assert property (##1 ref_delay_sel == $past(mode_s))
        else $error("reference delay select does not follow mode");

    for (genvar i = 0; i < csoc_pkg::CSOC_NUM_CLK; i++)
    begin : g_clk_chk
        a_clk_pd_off: assert property (
            (clk_pd[i] && !clk_src[i]) |=> clk_st[i] == csoc_pkg::CSOC_ST_OFF)
            else $error("clock output not off under power-down");

        a_clk_en_run: assert property (
            (!clk_pd[i] && !clk_src[i]) |=>
            (clk_st[i] == ($past(cfg_sync[csoc_pkg::CSOC_OFS_CLK_EN + i])
                ? csoc_pkg::CSOC_ST_RUN : csoc_pkg::CSOC_ST_LOW)))
            else $error("clock output state does not follow enable");

        // a falling output follows a low source
        a_clk_no_trunc: assert property (
            $fell(clock_output[i]) |-> !$past(clk_src[i]))
            else $error("clock output pulse cut short");

        a_clk_rest_low: assert property (
            clk_st[i] != csoc_pkg::CSOC_ST_RUN |=> !clock_output[i])
            else $error("clock output not low while stopped");

        a_clk_run_copy: assert property (
            clk_st[i] == csoc_pkg::CSOC_ST_RUN |=> clock_output[i] == $past(clk_src[i]))
            else $error("running clock output does not copy divider");

        // style applied at a safe point
        a_clk_style_set: assert property (
            !clk_src[i] |=> clock_output_style[i]
                == $past(cfg_sync[csoc_pkg::CSOC_OFS_CLK_STY + i]))
            else $error("clock output style not applied");

        // top amplitude code gives full swing
        a_clk_swing_top: assert property (
            (!clk_src[i] && cfg_sync[csoc_pkg::CSOC_OFS_CLK_AMP + 2*i +: 2] == 2'h3)
            |=> clock_output_swing_mv[10*i +: 10] == csoc_pkg::CSOC_SWING_11)
            else $error("clock output swing wrong for top code");
    end

    for (genvar r = 0; r < csoc_pkg::CSOC_NUM_REF; r++)
    begin : g_ref_chk
        // channel power-down switches SYSREF output off
        a_sys_chan_pd: assert property (
            (mode_s[r] && chan_pd_s[csoc_pkg::csoc_chan_of(r)] && !ref_src[r])
            |=> ref_st[r] == csoc_pkg::CSOC_ST_OFF)
            else $error("SYSREF output not off under channel power-down");

        // event powers enabled SYSREF output on
        a_sys_event_on: assert property (
            (mode_s[r] && !ref_pd[r] && sysref_event && !ref_src[r]
             && cfg_sync[csoc_pkg::CSOC_OFS_REF_EN + r])
            |=> ref_st[r] == csoc_pkg::CSOC_ST_RUN)
            else $error("SYSREF output not running during event");

        // no running SYSREF output outside an event
        a_sys_idle_off: assert property (
            (mode_s[r] && !sysref_event && !ref_src[r])
            |=> ref_st[r] != csoc_pkg::CSOC_ST_RUN)
            else $error("SYSREF output still running after event");

        // idle output with bias rests at midpoint
        a_sys_bias_mid: assert property (
            (mode_s[r] && !ref_pd[r] && !sysref_event && ref_bias[r] && !ref_src[r])
            |=> ref_st[r] == csoc_pkg::CSOC_ST_BIAS)
            else $error("biased SYSREF output not at midpoint");

        // no midpoint bias when bias type is 0
        a_bias_type_low: assert property (
            (!bias_type_s && !ref_src[r]) |=> ref_st[r] != csoc_pkg::CSOC_ST_BIAS)
            else $error("midpoint bias with bias type 0");

        // clock-mode reference follows its own power-down
        a_ref_clk_own: assert property (
            (!mode_s[r] && cfg_sync[csoc_pkg::CSOC_OFS_REF_PD + r] && !ref_src[r])
            |=> ref_st[r] == csoc_pkg::CSOC_ST_OFF)
            else $error("clock-mode reference ignores its power-down");

        // reference pulse ends only with its source
        a_ref_no_trunc: assert property (
            $fell(reference_output[r]) |-> !$past(ref_src[r]))
            else $error("reference output pulse cut short");

        a_ref_rest_low: assert property (
            ref_st[r] != csoc_pkg::CSOC_ST_RUN |=> !reference_output[r])
            else $error("reference output not low while stopped");

        // disabled SYSREF output held low during an event
        a_sys_en_low: assert property (
            (mode_s[r] && !ref_pd[r] && sysref_event && !ref_src[r]
             && !cfg_sync[csoc_pkg::CSOC_OFS_REF_EN + r])
            |=> ref_st[r] == csoc_pkg::CSOC_ST_LOW)
            else $error("disabled SYSREF output not held low");

        // SYSREF pulses come from the global divider
        a_sys_div_copy: assert property (
            (mode_s[r] && ref_st[r] == csoc_pkg::CSOC_ST_RUN)
            |=> reference_output[r] == $past(sysref_div))
            else $error("SYSREF output does not copy global divider");

        // clock-mode reference copies the channel divider
        a_ref_div_copy: assert property (
            (!mode_s[r] && ref_st[r] == csoc_pkg::CSOC_ST_RUN)
            |=> reference_output[r] == $past(chan_div[csoc_pkg::csoc_chan_of(r)]))
            else $error("clock-mode reference does not copy channel divider");

        // reference style applied at a safe point
        a_ref_style_set: assert property (
            !ref_src[r] |=> reference_output_style[r]
                == $past(cfg_sync[csoc_pkg::CSOC_OFS_REF_STY + r]))
            else $error("reference output style not applied");

        a_ref_swing_half: assert property (
            (!ref_src[r] && cfg_sync[csoc_pkg::CSOC_OFS_REF_AMP + 2*r +: 2] == 2'h1)
            |=> reference_output_swing_mv[10*r +: 10] == csoc_pkg::CSOC_SWING_01)
            else $error("reference output swing wrong for code 01");
    end

    // main scenarios
    c_sys_event_run: cover property (
        sysref_event && mode_s[3] && ref_st[3] == csoc_pkg::CSOC_ST_RUN);
    c_sys_bias_idle: cover property (ref_st[3] == csoc_pkg::CSOC_ST_BIAS);
    c_sys_held_low: cover property (
        sysref_event && mode_s[3] && ref_st[3] == csoc_pkg::CSOC_ST_LOW);
    c_clk_toggle: cover property (clock_output[9] ##1 !clock_output[9]);
    c_ref_clk_mode: cover property (
        !mode_s[3] && reference_output[3]);

endmodule

`default_nettype wire

/* verif/csoc_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// converter at the far side: counts sysref pulses it receives
// ----------------------------------------------------------------------
module csoc_conv_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       sysref_in,
    output logic [7:0]      pulse_cnt
);
    logic last;

    // rising edges only, so a held-high line counts once
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            last      <= 1'b0;
            pulse_cnt <= 8'h00;
        end
        else
        begin
            last <= sysref_in;
            if (sysref_in && !last)
                pulse_cnt <= pulse_cnt + 8'h01;
        end
    end
endmodule

`default_nettype wire

/* verif/clock_sysref_output_channel_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module clock_sysref_output_channel_ctrl_tb_top;
    localparam logic [1:0] S_OFF  = csoc_pkg::CSOC_ST_OFF;
    localparam logic [1:0] S_LOW  = csoc_pkg::CSOC_ST_LOW;
    localparam logic [1:0] S_RUN  = csoc_pkg::CSOC_ST_RUN;
    localparam logic [1:0] S_BIAS = csoc_pkg::CSOC_ST_BIAS;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        core_clk, rst_b, bias_type, sysref_div, sysref_event;
    logic [9:0]  clock_output_powerdown, clock_output_en, clock_output_style_sel;
    logic [19:0] clock_output_amp, clock_output_state;
    logic [7:0]  ref_output_mode_sel, ref_output_powerdown, ref_output_en;
    logic [7:0]  ref_output_style_sel, line_bias_ctrl, conv_cnt;
    logic [15:0] ref_output_amp, reference_output_state;
    logic [4:0]  chan_output_powerdown, chan_div;
    logic [9:0]  clock_output, clock_output_style;
    logic [99:0] clock_output_swing_mv;
    logic [7:0]  reference_output, reference_output_style, ref_div_sel, ref_delay_sel;
    logic [79:0] reference_output_swing_mv;
    int          fail_count, comparisons, i, c, k, a, cnt0;
    int          cks [2] = '{0, 9};
    int          chs [2] = '{0, 4};
    logic [9:0]  swing_tab [4] = '{10'h0FA, 10'h1F4, 10'h2EE, 10'h3E8};
    logic [2:0]  bt_tab  = 3'b101;
    logic [2:0]  sty_tab = 3'b100;
    logic [1:0]  bexp [3] = '{S_BIAS, S_OFF, S_OFF};

    csoc_chan_ctrl dut (.core_clk, .rst_b, .clock_output_powerdown, .clock_output_en,
        .clock_output_style_sel, .clock_output_amp, .ref_output_mode_sel,
        .ref_output_powerdown, .ref_output_en, .ref_output_style_sel, .ref_output_amp,
        .line_bias_ctrl, .chan_output_powerdown, .bias_type, .chan_div, .sysref_div,
        .sysref_event, .clock_output, .clock_output_state, .clock_output_style,
        .clock_output_swing_mv, .reference_output, .reference_output_state,
        .reference_output_style, .reference_output_swing_mv, .ref_div_sel,
        .ref_delay_sel);

    csoc_conv_model conv (.core_clk, .rst_b, .sysref_in(reference_output[3]),
        .pulse_cnt(conv_cnt));

    // ------------------------------------------------------------------
    // clock, helpers and closing
    // ------------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [1:0] ck_st(input int n);
        ck_st = clock_output_state[2*n+:2];
    endfunction

    function automatic logic [1:0] rf_st(input int n);
        rf_st = reference_output_state[2*n+:2];
    endfunction

    // inputs always move 1 ns after the edge, never racing it
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input logic [99:0] seen, input logic [99:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // generous bound: the whole sequence takes about 140 cycles
    initial
    begin
        repeat (3000) @(posedge core_clk);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        stop_test();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {clock_output_powerdown, clock_output_en, clock_output_style_sel} = '0;
        {clock_output_amp, ref_output_mode_sel, ref_output_powerdown} = '0;
        {ref_output_en, ref_output_style_sel, ref_output_amp, line_bias_ctrl} = '0;
        {chan_output_powerdown, bias_type, chan_div, sysref_div, sysref_event} = '0;
        rst_b = 1'b0;
        tick(2);
        chk(clock_output_state, 20'h0);
        chk(clock_output_swing_mv, {10{10'h0FA}});
        chk({ref_div_sel, ref_delay_sel, reference_output}, 24'h0);
        rst_b = 1'b1;
        $display("test reset done");
        // clock outputs of channel A and channel E, every amplitude code
        foreach (cks[m])
        begin
            i = cks[m];
            c = chs[m];
            for (a = 0; a < 4; a++)
            begin
                clock_output_en[i] = 1'b1;
                clock_output_amp[2*i+:2] = a[1:0];
                clock_output_style_sel[i] = a[0];
                tick(5);
                chk(ck_st(i), S_RUN);
                chk(clock_output_swing_mv[10*i+:10], swing_tab[a]);
                chk(clock_output_style[i], a[0]);
            end
            chk(ck_st(1), S_LOW);
            chan_div[c] = 1'b1;
            tick(1);
            chk(clock_output[i], 1'b1);
            clock_output_en[i] = 1'b0;
            tick(5);
            chk(ck_st(i), S_RUN);
            chk(clock_output[i], 1'b1);
            chan_div[c] = 1'b0;
            tick(3);
            chk(ck_st(i), S_LOW);
            chan_div[c] = 1'b1;
            tick(1);
            chk(clock_output[i], 1'b0);
            chan_div[c] = 1'b0;
            clock_output_powerdown[i] = 1'b1;
            clock_output_en[i] = 1'b1;
            tick(5);
            chk(ck_st(i), S_OFF);
            clock_output_powerdown[i] = 1'b0;
            chan_output_powerdown[c] = 1'b1;
            tick(5);
            chk(ck_st(i), S_OFF);
            chan_output_powerdown[c] = 1'b0;
            clock_output_en[i] = 1'b0;
        end
        $display("test clock outputs done");
        // reference output B0 in clock mode
        ref_output_en[3] = 1'b1;
        tick(5);
        chk(rf_st(3), S_RUN);
        chk(ck_st(3), S_LOW);
        chk({ref_div_sel[3], ref_delay_sel[3]}, 2'h0);
        chan_div[1] = 1'b1;
        tick(1);
        chk(reference_output[3], 1'b1);
        chan_div[1] = 1'b0;
        ref_output_powerdown[3] = 1'b1;
        tick(5);
        chk(rf_st(3), S_OFF);
        $display("test reference clock mode done");
        // same output in sysref mode; own power down is left set
        ref_output_mode_sel[3] = 1'b1;
        ref_output_amp[7:6] = 2'h1;
        tick(5);
        chk(rf_st(3), S_OFF);
        chk({ref_div_sel[3], ref_delay_sel[3]}, 2'h3);
        chk(reference_output_swing_mv[30+:10], 10'h1F4);
        cnt0 = conv_cnt;
        sysref_event = 1'b1;
        tick(2);
        chk(rf_st(3), S_RUN);
        repeat (3)
        begin
            sysref_div = 1'b1;
            tick(1);
            chk(reference_output[3], 1'b1);
            sysref_div = 1'b0;
            tick(1);
        end
        sysref_event = 1'b0;
        tick(3);
        chk(rf_st(3), S_OFF);
        chk(conv_cnt, cnt0 + 3);
        sysref_div = 1'b1;
        tick(1);
        chk(reference_output[3], 1'b0);
        sysref_div = 1'b0;
        ref_output_en[3] = 1'b0;
        tick(3);
        sysref_event = 1'b1;
        tick(2);
        chk(rf_st(3), S_LOW);
        chan_output_powerdown[1] = 1'b1;
        tick(5);
        chk(rf_st(3), S_OFF);
        sysref_event = 1'b0;
        chan_output_powerdown[1] = 1'b0;
        $display("test sysref mode done");
        // line bias against bias type and style
        line_bias_ctrl[3] = 1'b1;
        for (k = 0; k < 3; k++)
        begin
            bias_type = bt_tab[k];
            ref_output_style_sel[3] = sty_tab[k];
            tick(5);
            chk(rf_st(3), bexp[k]);
            chk(reference_output[3], 1'b0);
            chk(reference_output_style[3], sty_tab[k]);
        end
        ref_output_style_sel[3] = 1'b0;
        ref_output_en[3] = 1'b1;
        sysref_event = 1'b1;
        tick(5);
        chk(rf_st(3), S_RUN);
        sysref_event = 1'b0;
        tick(3);
        chk(rf_st(3), S_BIAS);
        $display("test line bias done");
        stop_test();
    end
endmodule

`default_nettype wire
